// >>> hdl/bidir_latch_register_transceiver.sv
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bidir_latch_register_transceiver
  import xcvr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // A port pins
  input wire logic [DATA_W-1:0] a_in,
  output logic [DATA_W-1:0] a_out,
  output logic a_oe,
  // B port pins
  input wire logic [DATA_W-1:0] b_in,
  output logic [DATA_W-1:0] b_out,
  output logic b_oe,
  // Forward path controls
  input wire logic clock_enable_n_fwd,
  input wire logic output_enable_n_fwd,
  input wire logic latch_enable_fwd,
  input wire logic capture_clock_fwd,
  // Reverse path controls
  input wire logic clock_enable_n_rev,
  input wire logic output_enable_n_rev,
  input wire logic latch_enable_rev,
  input wire logic capture_clock_rev,
  // Captured word streams, one per direction
  output logic [NUM_DIR-1:0] cap_valid,
  input wire logic [NUM_DIR-1:0] cap_ready,
  output logic [NUM_DIR-1:0][DATA_W-1:0] cap_data,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Register state
  logic [CTRL_W-1:0] ctrl_q;
  logic conflict_q;
  logic [NUM_DIR-1:0] ovf_q;
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // Per-direction state
  logic [NUM_DIR-1:0][DATA_W-1:0] din_pin;
  logic [NUM_DIR-1:0][DATA_W-1:0] din_s1_q;
  logic [NUM_DIR-1:0][DATA_W-1:0] din_s2_q;
  path_ctl_t [NUM_DIR-1:0] ctl_pin;
  path_ctl_t [NUM_DIR-1:0] ctl_s1_q;
  path_ctl_t [NUM_DIR-1:0] ctl_s2_q;
  path_ctl_t [NUM_DIR-1:0] ctl_sel;
  logic [NUM_DIR-1:0] clk_prev_q;
  logic [NUM_DIR-1:0] clk_rise;
  logic [NUM_DIR-1:0] capture;
  logic [NUM_DIR-1:0][DATA_W-1:0] store_q;
  logic [NUM_DIR-1:0][DATA_W-1:0] store_d;
  logic [NUM_DIR-1:0] oe_q;
  logic [NUM_DIR-1:0] buf_in_ready;

  assign din_pin[DIR_FWD] = a_in;
  assign din_pin[DIR_REV] = b_in;
  assign ctl_pin[DIR_FWD] = '{clk: capture_clock_fwd, le: latch_enable_fwd,
                              oe_n: output_enable_n_fwd, ce_n: clock_enable_n_fwd};
  assign ctl_pin[DIR_REV] = '{clk: capture_clock_rev, le: latch_enable_rev,
                              oe_n: output_enable_n_rev, ce_n: clock_enable_n_rev};

  // Pin outputs: each path drives the opposite port
  assign b_out = store_q[DIR_FWD];
  assign b_oe = oe_q[DIR_FWD];
  assign a_out = store_q[DIR_REV];
  assign a_oe = oe_q[DIR_REV];

  genvar d;
  generate
    for (d = 0; d < NUM_DIR; d++) begin : g_dir
      localparam int CTL_LSB = (d == DIR_FWD) ? CTRL_FWD_LSB : CTRL_REV_LSB;

      // Software override of the pin controls
      assign ctl_sel[d] = ctrl_q[CTRL_SW_LSB + d] ? path_ctl_t'(ctrl_q[CTL_LSB +: 4]) : ctl_s2_q[d];
      assign clk_rise[d] = ctl_sel[d].clk && !clk_prev_q[d];
      assign capture[d] = !ctl_sel[d].le && !ctl_sel[d].ce_n && clk_rise[d];
      // Transparent tracks the input; otherwise only a clocked capture loads
      assign store_d[d] = (ctl_sel[d].le || capture[d]) ? din_s2_q[d] : store_q[d];

      always_ff @(posedge aclk) begin
        din_s1_q[d] <= din_pin[d];
        din_s2_q[d] <= din_s1_q[d];
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctl_s1_q[d] <= CTL_IDLE;
          ctl_s2_q[d] <= CTL_IDLE;
          clk_prev_q[d] <= 1'b0;
          store_q[d] <= '0;
          oe_q[d] <= 1'b0;
        end else begin
          ctl_s1_q[d] <= ctl_pin[d];
          ctl_s2_q[d] <= ctl_s1_q[d];
          clk_prev_q[d] <= ctl_sel[d].clk;
          store_q[d] <= store_d[d];
          oe_q[d] <= !ctl_sel[d].oe_n;
        end
      end

      two_entry_buffer #(
        .WIDTH(DATA_W)
      ) u_cap_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(capture[d]),
        .in_ready(buf_in_ready[d]),
        .in_data(din_s2_q[d]),
        .out_valid(cap_valid[d]),
        .out_ready(cap_ready[d]),
        .out_data(cap_data[d])
      );

      transparent_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctl_sel[d].le |=> store_q[d] == $past(din_s2_q[d]))
        else $error("transparent path did not follow input");
      clocked_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_sel[d].le && !ctl_sel[d].ce_n && ctl_sel[d].clk && !clk_prev_q[d])
        |=> store_q[d] == $past(din_s2_q[d]))
        else $error("rising capture clock did not load data");
      clock_inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_sel[d].le && ctl_sel[d].ce_n) |=> $stable(store_q[d]))
        else $error("stored value changed while clock inhibited");
      latched_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_sel[d].le && !clk_rise[d]) |=> $stable(store_q[d]))
        else $error("latched value changed without clock edge");
      latch_close_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ($fell(ctl_sel[d].le) && !clk_rise[d]) |=> store_q[d] == $past(din_s2_q[d], 2))
        else $error("latch closing changed the output level");
      output_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 oe_q[d] == !$past(ctl_sel[d].oe_n))
        else $error("output enable does not follow control");
      capture_queued_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (capture[d] && buf_in_ready[d]) |=> cap_valid[d])
        else $error("captured word not queued");
    end
  endgenerate

  // AXI4-Lite handshakes
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire wr_ctrl = do_write && (aw_addr_q == CTRL_ADDR);
  wire wr_status = do_write && (aw_addr_q == STATUS_ADDR);
  wire wr_mapped = wr_ctrl || wr_status;
  wire do_read = s_axi_arvalid && !rvalid_q;
  wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] ctrl_merged = ({20'h00000, ctrl_q} & ~strb_mask) | (w_data_q & strb_mask);
  wire w1c_ok = w_strb_q[0];
  wire both_drive = oe_q[DIR_FWD] && oe_q[DIR_REV];
  wire [NUM_DIR-1:0] overflow = capture & ~buf_in_ready;
  wire [ST_W-1:0] status_word = {oe_q, cap_valid, ovf_q, conflict_q};
  wire rd_mapped = (s_axi_araddr == CTRL_ADDR) || (s_axi_araddr == STATUS_ADDR) ||
                   (s_axi_araddr == STORE_FWD_ADDR) || (s_axi_araddr == STORE_REV_ADDR);
  wire [31:0] rd_word = (s_axi_araddr == CTRL_ADDR) ? {20'h00000, ctrl_q} :
                        (s_axi_araddr == STATUS_ADDR) ? {25'h0000000, status_word} :
                        (s_axi_araddr == STORE_FWD_ADDR) ? {14'h0000, store_q[DIR_FWD]} :
                        (s_axi_araddr == STORE_REV_ADDR) ? {14'h0000, store_q[DIR_REV]} : 32'h00000000;
  // Sticky flags: a new event wins over a write-one clear
  wire conflict_d = both_drive || (conflict_q && !(wr_status && w1c_ok && w_data_q[ST_CONFLICT]));
  wire [NUM_DIR-1:0] ovf_d = overflow |
                             (ovf_q & ~({NUM_DIR{wr_status && w1c_ok}} & w_data_q[ST_OVF_LSB +: NUM_DIR]));

  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && !aw_have_q) begin
      aw_addr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else begin
      aw_have_q <= aw_have_q || s_axi_awvalid;
      w_have_q <= w_have_q || s_axi_wvalid;
      bvalid_q <= bvalid_q && !s_axi_bready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_word;
    end else begin
      rvalid_q <= rvalid_q && !s_axi_rready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      conflict_q <= 1'b0;
      ovf_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_merged[CTRL_W-1:0];
      end
      conflict_q <= conflict_d;
      ovf_q <= ovf_d;
    end
  end

  conflict_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (oe_q[DIR_FWD] && oe_q[DIR_REV]) |=> conflict_q)
    else $error("driver conflict not flagged");
  write_resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

endmodule : bidir_latch_register_transceiver
`default_nettype wire

// >>> inc/xcvr_pkg.sv
package xcvr_pkg;

  localparam int DATA_W = 18;
  localparam int NUM_DIR = 2;
  localparam int DIR_FWD = 0;
  localparam int DIR_REV = 1;
  localparam int BUF_DEPTH = 2;

  // Register byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] STORE_FWD_ADDR = 4'h8;
  localparam logic [3:0] STORE_REV_ADDR = 4'hc;

  // Control register fields
  localparam int CTRL_SW_LSB = 0;
  localparam int CTRL_FWD_LSB = 4;
  localparam int CTRL_REV_LSB = 8;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h330;

  // Status register fields
  localparam int ST_CONFLICT = 0;
  localparam int ST_OVF_LSB = 1;
  localparam int ST_BUFV_LSB = 3;
  localparam int ST_OE_LSB = 5;
  localparam int ST_W = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Path controls; bit order matches the control register nibble
  typedef struct packed {
    logic clk;
    logic le;
    logic oe_n;
    logic ce_n;
  } path_ctl_t;

  localparam path_ctl_t CTL_IDLE = '{clk: 1'b0, le: 1'b0, oe_n: 1'b1, ce_n: 1'b1};

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } cap_word_t;

endpackage : xcvr_pkg

// >>> hdl/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
  import xcvr_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [1:0][WIDTH-1:0] mem_q;
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : two_entry_buffer
`default_nettype wire

// >>> test/xcvr_cards.sv
`timescale 1ns/1ps
`default_nettype none
module xcvr_cards
  import xcvr_pkg::*;
(
  // Device pins
  input wire logic [DATA_W-1:0] a_out,
  input wire logic a_oe,
  input wire logic [DATA_W-1:0] b_out,
  input wire logic b_oe,
  // Card and backplane drive values
  input wire logic [DATA_W-1:0] a_drv,
  input wire logic [DATA_W-1:0] b_drv,
  // Resolved wire levels
  output logic [DATA_W-1:0] a_in,
  output logic [DATA_W-1:0] b_in
);
  // Far side drives a line only while the device has released it
  assign a_in = a_oe ? a_out : a_drv;
  assign b_in = b_oe ? b_out : b_drv;
endmodule : xcvr_cards
`default_nettype wire

// >>> test/bidir_latch_register_transceiver_test.sv
`timescale 1ns/1ps
`default_nettype none
module bidir_latch_register_transceiver_test;
  import xcvr_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [DATA_W-1:0] a_in, a_out, b_in, b_out;
  logic [DATA_W-1:0] a_drv = 0, b_drv = 0, v, w, y;
  logic a_oe, b_oe;
  logic [1:0] ce = 2'h3, oe = 2'h3, le = 2'h0, ck = 2'h0, cap_ready = 2'h0, cap_valid;
  logic [1:0][DATA_W-1:0] cap_data;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int fail_count = 0, tests_run = 0, seed = 32'h27f3ac39;
  // Model: expected output per direction and captured word queues
  logic [DATA_W-1:0] e [2];
  logic [DATA_W-1:0] q [2][$];
  always #20 aclk = ~aclk;
  bidir_latch_register_transceiver DUT (.*,
    .clock_enable_n_fwd(ce[0]), .output_enable_n_fwd(oe[0]), .latch_enable_fwd(le[0]), .capture_clock_fwd(ck[0]),
    .clock_enable_n_rev(ce[1]), .output_enable_n_rev(oe[1]), .latch_enable_rev(le[1]), .capture_clock_rev(ck[1]));
  xcvr_cards cards (.*);
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge aclk);
  endtask : tk
  function automatic logic [DATA_W-1:0] o(input int d);
    return d ? a_out : b_out;
  endfunction : o
  function automatic logic en(input int d);
    return d ? a_oe : b_oe;
  endfunction : en
  task automatic dr(input int d, input logic [DATA_W-1:0] x);
    if (d) b_drv <= x;
    else a_drv <= x;
  endtask : dr
  task automatic pin(input int d, input logic c, input logic n, input logic l, input logic k);
    ce[d] <= c;
    oe[d] <= n;
    le[d] <= l;
    ck[d] <= k;
    tk(4);
  endtask : pin
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt, input logic [1:0] rs);
    logic a, b, c;
    logic [1:0] r;
    int n;
    c = 0;
    n = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!c) begin
      @(negedge aclk);
      a = s_axi_awready;
      b = s_axi_wready;
      c = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 0;
      if (b) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    tk(1);
    chk(n, 3);
    chk(r, rs);
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] x, input logic [1:0] rs);
    logic a, c;
    logic [31:0] dt;
    logic [1:0] r;
    int n;
    c = 0;
    n = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!c) begin
      @(negedge aclk);
      a = s_axi_arready;
      c = s_axi_rvalid;
      dt = s_axi_rdata;
      r = s_axi_rresp;
      n++;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    tk(1);
    chk(n, 2);
    chk(dt & m, x);
    chk(r, rs);
  endtask : rd
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    fail_count++;
    stop_test;
  end
  initial begin
    e[0] = 0;
    e[1] = 0;
    tk(20);
    aresetn <= 1;
    tk(1);
    rd(CTRL_ADDR, 32'hfff, CTRL_RESET, RESP_OKAY);
    rd(4'h2, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(STORE_FWD_ADDR, 32'h1, RESP_SLVERR);
    for (int d = 0; d < 2; d++) begin
      v = $random(seed);
      dr(d, v);
      pin(d, 1, 0, 1, 0);
      chk(o(d), v);
      chk(en(d), 1);
      pin(d, 0, 0, 0, 0);
      w = $random(seed);
      dr(d, w);
      tk(4);
      chk(o(d), v);
      pin(d, 0, 0, 0, 1);
      chk(o(d), w);
      q[d].push_back(w);
      v = $random(seed);
      dr(d, v);
      pin(d, 0, 0, 1, 1);
      pin(d, 0, 0, 0, 1);
      dr(d, ~v);
      tk(4);
      chk(o(d), v);
      pin(d, 1, 0, 0, 0);
      dr(d, $random(seed));
      pin(d, 1, 0, 0, 1);
      chk(o(d), v);
      for (int k = 0; k < 2; k++) begin
        y = $random(seed);
        dr(d, y);
        pin(d, 0, 0, 0, 0);
        pin(d, 0, 0, 0, 1);
        if (q[d].size() < BUF_DEPTH) q[d].push_back(y);
        chk(o(d), y);
      end
      e[d] = y;
      rd(STATUS_ADDR, 32'h1 << (ST_OVF_LSB + d), 32'h1 << (ST_OVF_LSB + d), RESP_OKAY);
      while (q[d].size() > 0) begin
        chk(cap_valid[d], 1);
        chk(cap_data[d], q[d].pop_front());
        cap_ready[d] <= 1;
        tk(1);
        cap_ready[d] <= 0;
        tk(1);
      end
      chk(cap_valid[d], 0);
      chk(o(1 - d), e[1 - d]);
      pin(d, 1, 1, 0, 0);
      chk(en(d), 0);
    end
    wr(STATUS_ADDR, 32'h7, RESP_OKAY);
    rd(STATUS_ADDR, 32'h6, 32'h0, RESP_OKAY);
    wr(CTRL_ADDR, 32'h41, RESP_OKAY);
    rd(CTRL_ADDR, 32'hfff, 32'h41, RESP_OKAY);
    v = $random(seed);
    dr(0, v);
    tk(4);
    chk(b_out, v);
    chk(b_oe, 1);
    rd(STORE_FWD_ADDR, 32'hffffffff, v, RESP_OKAY);
    rd(STORE_REV_ADDR, 32'hffffffff, e[1], RESP_OKAY);
    rd(STATUS_ADDR, 32'h78, 32'h20, RESP_OKAY);
    wr(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
    stop_test;
  end
endmodule : bidir_latch_register_transceiver_test
`default_nettype wire
